// file: hw/sbl_link.sv
// Link side of the loader: SPI shift engine on the configuration clock.
// Assumes start arrives as a toggle and the frame word is stable meanwhile.
`timescale 1ns/1ps
`default_nettype none
module sbl_link
   import sbl_pkg::*;
(
   input wire logic link_clk_in, // Selected configuration clock
   input wire logic rst_in, // Asynchronous reset, active high
   input wire logic start_tgl_in, // Toggle: start a frame
   input wire logic stream_in, // Keep reading after the header
   input wire logic stop_tgl_in, // Toggle: end an open stream
   input wire logic [5:0] hdr_bits_in, // Header bit count
   input wire logic [47:0] hdr_in, // Header, MSB first
   input wire logic miso_in, // Flash data
   output logic sclk_en_out, // Gate for flash clock
   output logic cs_low_out, // Chip select, active low
   output logic mosi_out, // Data to flash
   output logic done_tgl_out, // Toggle: header-only frame ended
   output logic byte_tgl_out, // Toggle: byte ready
   output logic [7:0] byte_out // Received byte
);
   // ****************************************
   // Crossing and shift state
   // ****************************************
   logic [2:0] st_sync, stp_sync; // Two stages plus edge memory
   logic busy, next_busy, rd, next_rd;
   logic [5:0] cnt, next_cnt;
   logic [47:0] sh, next_sh;
   logic [2:0] bc, next_bc;
   logic [7:0] rx, next_rx;
   logic next_done, next_btgl, next_cs, next_mosi;
   logic [7:0] next_byte;
   // Next-value logic; edge detect only reads the second stage onward
   always_comb begin
      next_busy = busy; next_rd = rd; next_cnt = cnt; next_sh = sh;
      next_bc = bc; next_rx = rx; next_done = done_tgl_out;
      next_btgl = byte_tgl_out; next_byte = byte_out;
      next_cs = cs_low_out; next_mosi = mosi_out;
      if (!busy && (st_sync[1] ^ st_sync[2])) begin
         next_busy = 1'b1; next_cnt = hdr_bits_in; next_cs = 1'b0;
         next_mosi = hdr_in[47]; next_sh = {hdr_in[46:0], 1'b0};
      end else if (busy && !rd) begin
         next_cnt = cnt - 6'h01;
         next_mosi = sh[47];
         next_sh = {sh[46:0], 1'b0};
         if (cnt == 6'h01) begin
            if (stream_in) begin
               next_rd = 1'b1; next_bc = 3'h0;
            end else begin
               next_busy = 1'b0; next_cs = 1'b1; next_done = ~done_tgl_out;
            end
         end
      end else if (rd) begin
         // Continuous read: address auto-increments inside the flash
         next_rx = {rx[6:0], miso_in};
         next_bc = bc + 3'h1;
         if (bc == 3'h7) begin
            next_byte = {rx[6:0], miso_in}; next_btgl = ~byte_tgl_out;
         end
         if (stp_sync[1] ^ stp_sync[2]) begin
            next_rd = 1'b0; next_busy = 1'b0; next_cs = 1'b1;
         end
      end
   end
   // Registers only
   always_ff @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_sync <= 3'h0; stp_sync <= 3'h0; busy <= 1'b0; rd <= 1'b0;
         cnt <= 6'h00; sh <= 48'h0; bc <= 3'h0; rx <= 8'h00;
         done_tgl_out <= 1'b0; byte_tgl_out <= 1'b0; byte_out <= 8'h00;
         cs_low_out <= 1'b1; mosi_out <= 1'b0;
      end else begin
         st_sync <= {st_sync[1:0], start_tgl_in};
         stp_sync <= {stp_sync[1:0], stop_tgl_in};
         busy <= next_busy; rd <= next_rd; cnt <= next_cnt; sh <= next_sh;
         bc <= next_bc; rx <= next_rx; done_tgl_out <= next_done;
         byte_tgl_out <= next_btgl; byte_out <= next_byte;
         cs_low_out <= next_cs; mosi_out <= next_mosi;
      end
   end
   // Flash clock gate moves only while the link clock is low, so the
   // gated clock never shows a shortened first or last pulse
   always_ff @(negedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sclk_en_out <= 1'b0;
      end else begin
         sclk_en_out <= ~cs_low_out; // Clock runs only while selected
      end
   end
endmodule : sbl_link
`default_nettype wire

// file: hw/sbl_loader.sv
// Top of the serial bitstream loader: sequencing, config memory writes.
// Assumes the link clock is free running; flash pins are mode 0 SPI.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Write bitstream into config memory before user mode
// - Active mode: device sequences every flash access
// - Config clock: internal oscillator or external pin
// - Drive command and address to the flash
// - First transaction is the wake command
// - Wait at least 30 us before fast read
// - Three-byte mode reads from address zero
// - Four-byte mode reads from address zero
// - Accept one-bit configuration through JTAG
// - Wide passive widths refused when secured
// - Active load starts on reset release
// - Bad signature aborts, no user mode; the code checks sig_valid_in only when secure_in is set
module sbl_loader
   import sbl_pkg::*;
#(
   parameter int unsigned BITSTREAM_BYTES = 64, // Bytes to load
   parameter int unsigned AW = 6, // Config memory address width
   parameter int unsigned WAIT_CYC = WAKE_WAIT_CYC // Wake wait, in cycles
) (
   input wire logic core_clk_in, // Core clock, 40 MHz
   input wire logic rst_in, // Asynchronous reset, active high
   input wire logic config_reset_low_in, // Config reset pin, active low
   input wire logic link_clk_in, // Selected configuration clock
   input wire logic [1:0] mode_in, // Mode straps
   input wire logic addr4_in, // Flash uses 4-byte addressing
   input wire logic ext_clk_sel_in, // Use external config clock
   input wire logic secure_in, // Bitstream security enabled
   input wire logic [2:0] width_in, // Passive width code
   input wire logic sig_valid_in, // Authentication result
   input wire logic pas_valid_in, // Passive or JTAG byte strobe
   input wire logic [7:0] pas_data_in, // Passive or JTAG byte
   input wire logic miso_in, // Flash data
   output logic sclk_en_out, // Flash clock gate
   output logic cs_low_out, // Flash select, active low
   output logic mosi_out, // Flash data out
   output logic clk_sel_out, // Clock mux select
   output logic width_err_out, // Passive width refused
   output logic user_mode_out, // Normal operation entered
   output logic fail_out, // Configuration aborted
   output logic mem_we_out, // Config memory write
   output logic [AW-1:0] mem_addr_out, // Config memory address
   output logic [7:0] mem_data_out // Config memory data
);
   // ****************************************
   // Sequencer state
   // ****************************************
   sbl_state_e state, next_state;
   logic [2:0] cr_sync; // Reset pin synchroniser plus edge memory
   logic [2:0] dn_sync, by_sync; // Toggles back from link
   logic start_tgl, next_start_tgl, stop_tgl, next_stop_tgl;
   logic stream, next_stream;
   logic [5:0] hdr_bits, next_hdr_bits;
   logic [47:0] hdr, next_hdr;
   logic [31:0] wait_cnt, next_wait_cnt;
   logic [AW:0] count, next_count;
   logic [7:0] link_byte;
   logic next_we, next_user, next_fail, next_werr;
   logic [AW-1:0] next_addr;
   logic [7:0] next_data;
   logic [1:0] mode; // Strap caught after reset release
   logic passive_bad;
   logic rise, got_done, got_byte;
   assign rise = cr_sync[1] & ~cr_sync[2];
   assign got_done = dn_sync[1] ^ dn_sync[2];
   assign got_byte = by_sync[1] ^ by_sync[2];
   assign passive_bad = secure_in &&
      (width_in == WIDTH_X16 || width_in == WIDTH_X32);
   // ****************************************
   // Link engine in its own clock domain
   // ****************************************
   // Only toggles cross back; the byte word is held for eight link clocks,
   // so it is settled long before its toggle has passed the synchroniser
   logic link_done_tgl; // Toggle: header-only frame ended
   logic link_byte_tgl; // Toggle: a byte waits in link_byte
   sbl_link u_link (
      .link_clk_in(link_clk_in), .rst_in(rst_in), .start_tgl_in(start_tgl),
      .stream_in(stream), .stop_tgl_in(stop_tgl), .hdr_bits_in(hdr_bits),
      .hdr_in(hdr), .miso_in(miso_in), .sclk_en_out(sclk_en_out),
      .cs_low_out(cs_low_out), .mosi_out(mosi_out), .done_tgl_out(link_done_tgl),
      .byte_tgl_out(link_byte_tgl), .byte_out(link_byte)
   );
   // Next-state and output computation
   always_comb begin
      next_state = state; next_start_tgl = start_tgl; next_stop_tgl = stop_tgl;
      next_stream = stream; next_hdr_bits = hdr_bits; next_hdr = hdr;
      next_wait_cnt = wait_cnt; next_count = count; next_we = 1'b0;
      next_addr = mem_addr_out; next_data = mem_data_out;
      next_user = user_mode_out; next_fail = fail_out;
      next_werr = (mode == MODE_PASSIVE) && passive_bad;
      unique case (state)
         SBL_IDLE: begin
            if (rise && mode == MODE_ACTIVE) begin
               next_hdr = {CMD_WAKE, 40'h0};
               next_hdr_bits = WAKE_BITS; next_stream = 1'b0;
               next_start_tgl = ~start_tgl; next_state = SBL_WAKE;
            end else if (rise) begin
               // Passive and JTAG: master paces the data itself
               next_count = '0; next_state = SBL_READ;
            end
         end
         SBL_WAKE: begin
            if (got_done) begin
               next_wait_cnt = 32'(WAIT_CYC); next_state = SBL_WAIT;
            end
         end
         SBL_WAIT: begin
            next_wait_cnt = wait_cnt - 32'h1;
            if (wait_cnt <= 32'h1) begin
               if (addr4_in) begin
                  next_hdr = {CMD_FAST_READ4, START_ADDR, 8'h00};
                  next_hdr_bits = READ4_BITS;
               end else begin
                  next_hdr = {CMD_FAST_READ3, START_ADDR[23:0], 16'h0};
                  next_hdr_bits = READ3_BITS;
               end
               next_stream = 1'b1; next_count = '0;
               next_start_tgl = ~start_tgl; next_state = SBL_READ;
            end
         end
         SBL_READ: begin
            // Bytes from link (active) or from the pins (passive, JTAG)
            if (mode == MODE_ACTIVE ? got_byte : (pas_valid_in && !next_werr)) begin
               next_we = 1'b1;
               next_addr = count[AW-1:0];
               next_data = (mode == MODE_ACTIVE) ? link_byte : pas_data_in;
               next_count = count + 1'b1;
               if (count == (AW+1)'(BITSTREAM_BYTES - 1)) begin
                  next_stop_tgl = ~stop_tgl; next_state = SBL_AUTH;
               end
            end
         end
         SBL_AUTH: begin
            if (secure_in && !sig_valid_in) begin
               next_fail = 1'b1; next_state = SBL_FAIL;
            end else begin
               next_user = 1'b1; next_state = SBL_USER;
            end
         end
         SBL_USER: next_state = SBL_USER;
         SBL_FAIL: next_state = SBL_FAIL;
         default: next_state = SBL_IDLE;
      endcase
   end
   // Registers only; strap catch is clocked in idle, reset loads MODE_ACTIVE
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= SBL_IDLE; cr_sync <= 3'h0; dn_sync <= 3'h0; by_sync <= 3'h0;
         start_tgl <= 1'b0; stop_tgl <= 1'b0; stream <= 1'b0;
         hdr_bits <= 6'h00; hdr <= 48'h0; wait_cnt <= 32'h0; count <= '0;
         mem_we_out <= 1'b0; mem_addr_out <= '0; mem_data_out <= 8'h00;
         user_mode_out <= 1'b0; fail_out <= 1'b0; width_err_out <= 1'b0;
         clk_sel_out <= 1'b0; mode <= MODE_ACTIVE;
      end else begin
         cr_sync <= {cr_sync[1:0], config_reset_low_in};
         dn_sync <= {dn_sync[1:0], link_done_tgl};
         by_sync <= {by_sync[1:0], link_byte_tgl};
         if (state == SBL_IDLE) begin
            mode <= mode_in;
            clk_sel_out <= ext_clk_sel_in;
         end
         state <= next_state; start_tgl <= next_start_tgl;
         stop_tgl <= next_stop_tgl; stream <= next_stream;
         hdr_bits <= next_hdr_bits; hdr <= next_hdr; wait_cnt <= next_wait_cnt;
         count <= next_count; mem_we_out <= next_we; mem_addr_out <= next_addr;
         mem_data_out <= next_data; user_mode_out <= next_user;
         fail_out <= next_fail; width_err_out <= next_werr;
      end
   end
   // ****************************************
   // Checks
   // ****************************************
   logic [31:0] gap; // Cycles since wake frame ended
   // Counts from the end of the wake frame; saturates rather than wraps
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) gap <= 32'h0;
      else if (state == SBL_WAKE) gap <= 32'h0;
      else if (gap != 32'hFFFFFFFF) gap <= gap + 32'h1;
   end
   logic [AW-1:0] last_addr; // Address of the previous memory write
   logic wr_seen; // A write has happened since reset
   // Remember the last write so the next one can be held against it
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         last_addr <= '0;
         wr_seen <= 1'b0;
      end else if (mem_we_out) begin
         last_addr <= mem_addr_out;
         wr_seen <= 1'b1;
      end
   end
   chk_wait_before_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (state == SBL_WAIT && next_state == SBL_READ) |-> gap >= WAIT_CYC - 1)
      else $error("fast read issued before wake wait");
   chk_fail_no_user: assert property (@(posedge core_clk_in) disable iff (rst_in)
      fail_out |-> !user_mode_out) else $error("user mode after failed auth");
   chk_wide_refused: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (width_err_out && mode != MODE_ACTIVE) |-> !mem_we_out)
      else $error("wide secured passive write taken");
   chk_wake_first: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (state == SBL_IDLE && next_state == SBL_WAKE) |=> hdr[47:40] == CMD_WAKE)
      else $error("first frame is not wake");
   chk_read_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (state == SBL_WAIT && next_state == SBL_READ) |=> hdr[39:16] == 24'h0)
      else $error("read address not zero");
   chk_user_after_load: assert property (@(posedge core_clk_in) disable iff (rst_in)
      $rose(user_mode_out) |-> $past(state) == SBL_AUTH)
      else $error("user mode without load");
   chk_start_on_rise: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (state == SBL_IDLE && rise && mode == MODE_ACTIVE) |=> state == SBL_WAKE)
      else $error("active load not started");
   chk_write_addr: assert property (@(posedge core_clk_in) disable iff (rst_in)
      mem_we_out |-> mem_addr_out == (wr_seen ? last_addr + 1'b1 : '0))
      else $error("config address not consecutive");
   chk_read4_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (state == SBL_WAIT && next_state == SBL_READ && addr4_in)
      |=> hdr[47:40] == CMD_FAST_READ4 && hdr[39:8] == 32'h0)
      else $error("four-byte read not from address zero");
endmodule : sbl_loader
`default_nettype wire

// file: hw/sbl_pkg.sv
// Shared constants for the serial bitstream loader.
// Assumes a 40 MHz core clock and an SPI flash that accepts mode 0.
package sbl_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CORE_CLK_HZ = 40_000_000; // Core clock rate
   localparam int unsigned WAKE_WAIT_US = 30; // Least wait after wake command
   localparam int unsigned WAKE_WAIT_CYC =
      (WAKE_WAIT_US * (CORE_CLK_HZ / 1_000_000) > 0) ?
      WAKE_WAIT_US * (CORE_CLK_HZ / 1_000_000) : 1; // Cycles, at least one
   localparam int unsigned PASSIVE_HOLD_US = 32; // Master hold-off after reset
   // ****************************************
   // Flash commands and addresses
   // ****************************************
   localparam logic [7:0] CMD_WAKE = 8'hAB; // Release from power-down
   localparam logic [7:0] CMD_FAST_READ3 = 8'h0B; // Fast read, 3-byte address
   localparam logic [7:0] CMD_FAST_READ4 = 8'h0C; // Fast read, 4-byte address
   localparam logic [31:0] START_ADDR = 32'h00000000; // Bitstream start
   localparam logic [5:0] WAKE_BITS = 6'h08; // Bits in wake frame
   localparam logic [5:0] READ3_BITS = 6'h28; // Cmd, 24 addr, 8 dummy
   localparam logic [5:0] READ4_BITS = 6'h30; // Cmd, 32 addr, 8 dummy
   // ****************************************
   // Mode encodings
   // ****************************************
   localparam logic [1:0] MODE_ACTIVE = 2'h0; // Device masters the flash
   localparam logic [1:0] MODE_PASSIVE = 2'h1; // External master drives
   localparam logic [1:0] MODE_JTAG = 2'h2; // Test port path
   localparam logic [2:0] WIDTH_X1 = 3'h0; // Passive width codes
   localparam logic [2:0] WIDTH_X16 = 3'h4;
   localparam logic [2:0] WIDTH_X32 = 3'h5;
   typedef enum logic [2:0] {SBL_IDLE, SBL_WAKE, SBL_WAIT, SBL_READ, SBL_AUTH,
      SBL_USER, SBL_FAIL} sbl_state_e;
endpackage : sbl_pkg

// file: testbench/sbl_flash_model.sv
// Behavioural serial flash on the far side of the loader's SPI pins.
// Assumes mode 0: bits taken on rising clock, data changed on falling.
`timescale 1ns/1ps
`default_nettype none
module sbl_flash_model (
   input wire logic link_clk_in, // Free running link clock
   input wire logic rst_in, // Asynchronous reset, active high
   input wire logic sclk_en_in, // Clock gate from loader
   input wire logic cs_low_in, // Select, active low
   input wire logic mosi_in, // Command and address bits
   input wire logic addr4_in, // Four-byte addressing
   input wire logic [7:0] salt_in, // Content seed
   output logic miso_out, // Data to loader
   output logic [7:0] first_cmd_out, // First command seen
   output logic [7:0] cmd_out, // Latest command seen
   output logic [31:0] addr_out // Latest address seen
);
   logic [8:0] cnt; // Rising edges in this frame
   logic [39:0] hdr; // Shifted header bits
   logic seen; // First command captured
   logic [8:0] hb; // Header length with dummy byte
   logic [8:0] b; // Data bit index
   logic [7:0] cur; // Stored byte at the current index
   assign hb = addr4_in ? 9'h030 : 9'h028;
   assign b = cnt - hb;
   assign cur = 8'(b[8:3] * 8'h1D) ^ salt_in;
   // ****************************************
   // Header capture
   // ****************************************
   always @(posedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt <= '0;
         seen <= 1'b0;
         first_cmd_out <= '0;
         cmd_out <= '0;
         addr_out <= '1;
      end else if (cs_low_in) begin
         cnt <= '0; // Deselected: next frame starts afresh
      end else if (sclk_en_in) begin
         cnt <= cnt + 9'h001;
         hdr <= {hdr[38:0], mosi_in};
         if (cnt == 9'h007) begin
            cmd_out <= {hdr[6:0], mosi_in};
            if (!seen) begin
               first_cmd_out <= {hdr[6:0], mosi_in};
            end
            seen <= 1'b1;
         end
         if (cnt == (addr4_in ? 9'h027 : 9'h01F)) begin
            addr_out <= addr4_in ? {hdr[30:0], mosi_in} : {8'h00, hdr[22:0], mosi_in};
         end
      end
   end
   // Data after the header; junk that changes every cycle otherwise,
   // so a loader sampling at the wrong time sees no stale value
   always @(negedge link_clk_in or posedge rst_in) begin
      if (rst_in) begin
         miso_out <= 1'b0;
      end else if (!cs_low_in && cnt >= hb) begin
         miso_out <= cur[3'h7 - b[2:0]];
      end else begin
         miso_out <= ~miso_out;
      end
   end
endmodule : sbl_flash_model
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the loader: active, passive and test port paths.
// Assumes the flash model beside it and a free running link clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sbl_pkg::*;
   logic core_clk_in = 0, link_clk = 0, rst_in = 1, cfg_n = 0;
   logic [1:0] mode = MODE_ACTIVE;
   logic addr4 = 0, ext_sel = 0, secure = 0, sig_ok = 1, pv = 0, miso;
   logic [2:0] width = WIDTH_X1;
   logic [7:0] pd = '0, salt = '0, fc, cmd;
   logic [31:0] addr;
   logic sclk_en, cs_low, mosi, clk_sel, werr, user, fail, we, prev_cs;
   logic [5:0] maddr;
   logic [7:0] mdata;
   logic [7:0] exp_mem [0:3]; // Expected config memory image
   int error_cnt = 0, samples_checked = 0, wr_cnt, gap, falls, cyc = 0;
   always #12.5 core_clk_in = ~core_clk_in;
   initial #7 forever #62.5 link_clk = ~link_clk;
   sbl_loader #(.BITSTREAM_BYTES(4), .AW(6)) dut_u (.core_clk_in(core_clk_in),
      .rst_in(rst_in), .config_reset_low_in(cfg_n), .link_clk_in(link_clk), .mode_in(mode),
      .addr4_in(addr4), .ext_clk_sel_in(ext_sel), .secure_in(secure), .width_in(width),
      .sig_valid_in(sig_ok), .pas_valid_in(pv), .pas_data_in(pd), .miso_in(miso),
      .sclk_en_out(sclk_en), .cs_low_out(cs_low), .mosi_out(mosi), .clk_sel_out(clk_sel),
      .width_err_out(werr), .user_mode_out(user), .fail_out(fail), .mem_we_out(we),
      .mem_addr_out(maddr), .mem_data_out(mdata));
   sbl_flash_model flash_u (.link_clk_in(link_clk), .rst_in(rst_in), .sclk_en_in(sclk_en),
      .cs_low_in(cs_low), .mosi_in(mosi), .addr4_in(addr4), .salt_in(salt), .miso_out(miso),
      .first_cmd_out(fc), .cmd_out(cmd), .addr_out(addr));
   // ****************************************
   // Shared checks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask : chk
   task automatic results;
      if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results
   // Flash content as the model stores it
   function automatic logic [7:0] fbyte(input int i);
      return (i[7:0] * 8'h1D) ^ salt;
   endfunction : fbyte
   // Wide passive widths are refused under security
   function automatic logic exp_refused(input logic [1:0] m, input logic s, input logic [2:0] w);
      return m == MODE_PASSIVE && s && (w == WIDTH_X16 || w == WIDTH_X32);
   endfunction : exp_refused
   // Memory write watcher and wake gap counter; cleared by reset
   always @(posedge core_clk_in) begin
      prev_cs <= cs_low;
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end else if (rst_in) begin
         wr_cnt <= 0;
         falls <= 0;
         gap <= 0;
      end else begin
         if (we === 1'b1) begin
            chk("mem_addr", wr_cnt, maddr);
            chk("mem_data", exp_mem[wr_cnt[1:0]], mdata);
            wr_cnt <= wr_cnt + 1;
         end
         if (cs_low === 1'b1) gap <= gap + 1;
         if (prev_cs === 1'b1 && cs_low === 1'b0) begin
            falls <= falls + 1;
            if (falls == 1) chk("wake_gap_ok", 1, gap >= WAKE_WAIT_CYC);
            gap <= 0;
         end
      end
   end
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic boot(input logic [1:0] m, input logic a4, sec, sv, input logic [2:0] w);
      @(posedge core_clk_in);
      rst_in <= 1;
      cfg_n <= 0;
      mode <= m;
      addr4 <= a4;
      secure <= sec;
      sig_ok <= sv;
      width <= w;
      ext_sel <= 1'($urandom);
      salt <= 8'($urandom);
      repeat (20) @(posedge core_clk_in);
      rst_in <= 0;
      repeat (3) @(posedge core_clk_in);
      cfg_n <= 1;
   endtask : boot
   task automatic run_active(input logic a4, sv);
      boot(MODE_ACTIVE, a4, 1'b1, sv, WIDTH_X1);
      for (int i = 0; i < 4; i++) exp_mem[i] = fbyte(i);
      for (int i = 0; i < 3000 && user !== 1'b1 && fail !== 1'b1; i++) @(posedge core_clk_in);
      @(posedge core_clk_in);
      chk("first_cmd", CMD_WAKE, fc);
      chk("read_cmd", a4 ? CMD_FAST_READ4 : CMD_FAST_READ3, cmd);
      chk("read_addr", START_ADDR, addr);
      chk("clk_sel", ext_sel, clk_sel);
      chk("bytes_written", 4, wr_cnt);
      chk("user_mode", sv, user);
      chk("fail", !sv, fail);
   endtask : run_active
   initial begin
      logic [2:0] w;
      logic [1:0] m;
      logic refused;
      void'($urandom(50));
      run_active(1'b0, 1'b1);
      run_active(1'b1, 1'b0);
      run_active(1'b1, 1'b1);
      // Passive width and security combinations, then the test port
      for (int k = 0; k < 5; k++) begin
         // Wide open, X16 secured, random narrow secured, X32 secured, test port
         w = (k == 1) ? WIDTH_X16 : ((k == 0 || k == 3) ? WIDTH_X32 : 3'($urandom_range(3)));
         m = (k == 4) ? MODE_JTAG : MODE_PASSIVE;
         refused = exp_refused(m, k != 0, w);
         boot(m, 1'b0, k != 0, 1'b1, w);
         for (int i = 0; i < 4; i++) exp_mem[i] = 8'($urandom);
         repeat (PASSIVE_HOLD_US * 40 + 20) @(posedge core_clk_in);
         for (int i = 0; i < 4; i++) begin
            @(posedge core_clk_in);
            pv <= 1;
            pd <= exp_mem[i];
            @(posedge core_clk_in);
            pv <= 0;
         end
         repeat (10) @(posedge core_clk_in);
         chk("width_err", refused, werr);
         chk("pas_bytes", refused ? 0 : 4, wr_cnt);
         chk("pas_user", !refused, user);
      end
      results();
   end
endmodule : tb
`default_nettype wire
